// ### hdl/wfpc_pulse_guard.sv
`timescale 1ns/1ps
`default_nettype none


module wfpc_pulse_guard
  import wfpc_pkg::*;
#(
  parameter int unsigned PROG_CNT = PROG_CYCLES
) (
  // core clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // serial link
  input  wire logic               frame_clk,
  input  wire logic               sel,
  input  wire logic               din,
  input  wire logic               prot_en,
  output logic                    dout,
  output logic                    dout_oe_n,
  // memory read-back
  input  wire logic [ADDR_W-1:0]  rd_addr,
  output logic [WORD_W-1:0]       rd_data_q,
  // frame verdicts
  output logic                    accept_pulse,
  output logic                    reject_pulse,
  output logic [CNT_W-1:0]        last_cnt_q,
  output logic                    busy,
  output logic                    guard_store_pulse,
  output logic                    guard_erase_pulse,
  output logic [ADDR_W-1:0]       guard_addr_q
);

  wfpc_frame_if frm ();

  wfpc_link_capture u_link (
    .frame_clk (frame_clk),
    .sel       (sel),
    .din       (din),
    .frm       (frm.link)
  );

  // ==========================================================================
  // synchronisers
  logic sel_s1_q, sel_s2_q, sel_s3_q;
  logic tgl_s1_q, tgl_s2_q, tgl_seen_q;
  logic pe_s1_q, pe_s2_q;
  logic frame_end;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
      sel_s3_q <= 1'b0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      pe_s1_q  <= 1'b0;
      pe_s2_q  <= 1'b0;
    end else begin
      sel_s1_q <= sel;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      tgl_s1_q <= frm.start_tgl;
      tgl_s2_q <= tgl_s1_q;
      pe_s1_q  <= prot_en;
      pe_s2_q  <= pe_s1_q;
    end
  end

  // the start toggle lives in the link domain; hold it clear during reset
  logic hold_rst_q;
  always_ff @(posedge ref_clk) begin
    hold_rst_q <= rst;
  end
  assign frm.hold_rst = hold_rst_q;

  assign frame_end = sel_s3_q && !sel_s2_q;

  // ==========================================================================
  // instruction class and its required count
  logic              chk_valid;
  logic [CNT_W-1:0]  req_cnt;
  logic [IDX_W-1:0]  req_words;
  logic              is_fill;
  logic              is_gstore;
  logic              is_gerase;
  logic [CNT_W-1:0]  page_len;
  logic [CNT_W-1:0]  page_extra;

  assign page_extra = frm.pulse_cnt - PULSE_WORD_END;

  always_comb begin
    chk_valid = 1'b0;
    req_cnt   = '0;
    req_words = IDX_ZERO;
    is_fill   = 1'b0;
    is_gstore = 1'b0;
    is_gerase = 1'b0;
    page_len  = PULSE_WORD_END;
    if (pe_s2_q) begin
      if (frm.opcode == OP_GUARD) begin
        chk_valid = 1'b1;
        req_cnt   = REQ_GUARD;
        is_gstore = 1'b1;
      end else if (frm.opcode == OP_EXT && frm.addr[ADDR_W-1 -: 2] == EXT_GUARD_CLR) begin
        chk_valid = 1'b1;
        req_cnt   = REQ_GUARD;
        is_gerase = 1'b1;
      end
    end else begin
      unique case (frm.opcode)
        OP_WORD_WRITE: begin
          chk_valid = 1'b1;
          req_cnt   = REQ_WORD_WRITE;
          req_words = IDX_ONE;
        end
        OP_PAGE: begin
          // one to four whole words; the count must land on a word boundary
          if (frm.pulse_cnt >= PULSE_WORD_END && page_extra[3:0] == 4'h0 &&
              page_extra[6] == 1'b0) begin
            page_len = frm.pulse_cnt;
          end
          chk_valid = 1'b1;
          req_cnt   = page_len;
          req_words = IDX_W'((page_len - PULSE_WORD_END) >> 4) + IDX_ONE;
        end
        OP_EXT: begin
          if (frm.addr[ADDR_W-1 -: 2] == EXT_FILL_ALL) begin
            chk_valid = 1'b1;
            req_cnt   = REQ_FILL_ALL;
            req_words = IDX_ALL;
            is_fill   = 1'b1;
          end
        end
        default: begin
          chk_valid = 1'b0;
        end
      endcase
    end
  end

  logic fresh;
  logic cnt_ok;
  logic go;

  assign fresh  = frame_end && (tgl_s2_q != tgl_seen_q);
  assign cnt_ok = (frm.pulse_cnt == req_cnt);
  assign go     = fresh && !busy && chk_valid && cnt_ok;

  // ==========================================================================
  // programming sequencer
  wfpc_state_t        state_q;
  logic [PROG_W-1:0]  prog_q;
  logic [IDX_W-1:0]   idx_q;
  logic [IDX_W-1:0]   nwords_q;
  logic               fill_q;
  logic [ADDR_W-1:0]  base_q;
  logic [PAGE_WORDS-1:0][WORD_W-1:0] data_q;

  assign busy = (state_q == ST_PROG);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      prog_q  <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_DONE: begin
          if (go) begin
            state_q <= ST_PROG;
            prog_q  <= PROG_W'(PROG_CNT - 1);
          end else if (state_q == ST_DONE && !sel_s2_q) begin
            state_q <= ST_IDLE;
          end
        end
        ST_PROG: begin
          if (prog_q == '0) begin
            state_q <= ST_DONE;
          end else begin
            prog_q <= prog_q - PROG_W'(1);
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tgl_seen_q <= 1'b0;
      idx_q      <= IDX_ZERO;
      nwords_q   <= IDX_ZERO;
      fill_q     <= 1'b0;
      base_q     <= '0;
      data_q     <= '0;
    end else begin
      if (frame_end) begin
        tgl_seen_q <= tgl_s2_q;
      end
      if (go) begin
        idx_q    <= IDX_ZERO;
        nwords_q <= req_words;
        fill_q   <= is_fill;
        base_q   <= frm.addr;
        data_q   <= frm.words;
      end else if (busy && idx_q != nwords_q) begin
        idx_q <= idx_q + IDX_ONE;
      end
    end
  end

  // ==========================================================================
  // storage; one word per cycle, so a fill needs PROG_CNT of at least 256
  logic [WORD_W-1:0] mem_q [MEM_WORDS];
  logic [ADDR_W-1:0] wr_addr;
  logic [WORD_W-1:0] wr_data;

  assign wr_addr = fill_q ? idx_q[ADDR_W-1:0]
                          : {base_q[ADDR_W-1:2], base_q[1:0] + idx_q[1:0]};
  assign wr_data = fill_q ? data_q[0] : data_q[idx_q[1:0]];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_q[i] <= ERASED_WORD;
      end
    end else if (busy && idx_q != nwords_q) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_q <= ERASED_WORD;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

  // ==========================================================================
  // verdicts and guard requests
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      accept_pulse      <= 1'b0;
      reject_pulse      <= 1'b0;
      guard_store_pulse <= 1'b0;
      guard_erase_pulse <= 1'b0;
      guard_addr_q      <= '0;
      last_cnt_q        <= '0;
    end else begin
      accept_pulse      <= go;
      reject_pulse      <= fresh && !busy && chk_valid && !cnt_ok;
      guard_store_pulse <= go && is_gstore;
      guard_erase_pulse <= go && is_gerase;
      if (go && is_gstore) begin
        guard_addr_q <= frm.addr;
      end
      if (fresh) begin
        last_cnt_q <= frm.pulse_cnt;
      end
    end
  end

  // ==========================================================================
  // ready/busy on the data pin while selected after a programming start
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dout      <= 1'b1;
      dout_oe_n <= 1'b1;
    end else begin
      dout      <= !busy;
      dout_oe_n <= !(sel_s2_q && state_q != ST_IDLE);
    end
  end

endmodule // wfpc_pulse_guard

`default_nettype wire

// ### hdl/wfpc_pkg.sv
`default_nettype none

package wfpc_pkg;

  // ==========================================================================
  // frame geometry
  localparam int unsigned CNT_W      = 7;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned PAGE_WORDS = 4;
  localparam int unsigned MEM_WORDS  = 256;
  localparam int unsigned IDX_W      = 9;

  localparam logic [CNT_W-1:0] CNT_MAX        = 7'h7F;
  localparam logic [CNT_W-1:0] PULSE_START    = 7'h01;
  localparam logic [CNT_W-1:0] PULSE_OP_END   = 7'h03;
  localparam logic [CNT_W-1:0] PULSE_ADDR_END = 7'h0B;
  localparam logic [CNT_W-1:0] PULSE_WORD_END = 7'h1B;
  localparam logic [CNT_W-1:0] PULSE_WORD_LEN = 7'h10;

  // ==========================================================================
  // required pulse counts per checked instruction
  localparam logic [CNT_W-1:0] REQ_WORD_WRITE = 7'h1B;
  localparam logic [CNT_W-1:0] REQ_FILL_ALL   = 7'h1B;
  localparam logic [CNT_W-1:0] REQ_GUARD      = 7'h0B;

  // ==========================================================================
  // opcodes; extended group selected by the two top address bits
  localparam logic [1:0] OP_EXT        = 2'h0;
  localparam logic [1:0] OP_WORD_WRITE = 2'h1;
  localparam logic [1:0] OP_PAGE       = 2'h3;
  localparam logic [1:0] OP_GUARD      = 2'h3;
  localparam logic [1:0] EXT_FILL_ALL  = 2'h1;
  localparam logic [1:0] EXT_GUARD_CLR = 2'h3;

  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [IDX_W-1:0]  IDX_ALL     = 9'h100;
  localparam logic [IDX_W-1:0]  IDX_ONE     = 9'h001;
  localparam logic [IDX_W-1:0]  IDX_ZERO    = 9'h000;

  // ==========================================================================
  // self-timed programming
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PROG_TIME_NS  = 5000000;
  localparam int unsigned PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned PROG_W        = 20;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_DONE = 2'b11
  } wfpc_state_t;

endpackage

`default_nettype wire

// ### hdl/wfpc_frame_if.sv
`timescale 1ns/1ps
`default_nettype none

// frame snapshot handed from the serial-clock side to the core side
interface wfpc_frame_if;
  import wfpc_pkg::*;
  logic [CNT_W-1:0]                   pulse_cnt;
  logic [1:0]                         opcode;
  logic [ADDR_W-1:0]                  addr;
  logic [PAGE_WORDS-1:0][WORD_W-1:0]  words;
  logic                               start_tgl;
  logic                               hold_rst;

  modport link (output pulse_cnt, output opcode, output addr, output words,
                output start_tgl, input hold_rst);
  modport core (input pulse_cnt, input opcode, input addr, input words,
                input start_tgl, output hold_rst);
endinterface

`default_nettype wire

// ### hdl/wfpc_link_capture.sv
`timescale 1ns/1ps
`default_nettype none

module wfpc_link_capture
  import wfpc_pkg::*;
(
  // serial link
  input  wire logic  frame_clk,
  input  wire logic  sel,
  input  wire logic  din,
  // snapshot to core
  wfpc_frame_if.link frm
);

  logic               started_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [WORD_W-1:0]  sh_q;
  logic [CNT_W-1:0]   cnt_d;
  logic [WORD_W-1:0]  sh_d;
  logic [CNT_W-1:0]   word_pos;

  assign cnt_d    = (cnt_q == CNT_MAX) ? CNT_MAX : cnt_q + 7'h01;
  assign sh_d     = {sh_q[WORD_W-2:0], din};
  assign word_pos = cnt_d - PULSE_WORD_END;

  // ==========================================================================
  // pulse counter, cleared by the frame itself since the clock may stop
  always_ff @(posedge frame_clk or negedge sel) begin
    if (!sel) begin
      started_q <= 1'b0;
      cnt_q     <= '0;
      sh_q      <= '0;
    end else if (!started_q) begin
      started_q <= din;
      cnt_q     <= din ? PULSE_START : '0;
    end else begin
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
    end
  end

  // ==========================================================================
  // start toggle tells the core a fresh frame exists
  always_ff @(posedge frame_clk or posedge frm.hold_rst) begin
    if (frm.hold_rst) begin
      frm.start_tgl <= 1'b0;
    end else if (sel && !started_q && din) begin
      frm.start_tgl <= ~frm.start_tgl;
    end
  end

  // ==========================================================================
  // snapshot survives the fall of select; the core reads it only after it
  // has seen select low through its synchroniser, when nothing moves here
  always_ff @(posedge frame_clk) begin
    if (sel) begin
      if (!started_q) begin
        frm.pulse_cnt <= din ? PULSE_START : '0;
      end else begin
        frm.pulse_cnt <= cnt_d;
        if (cnt_d == PULSE_OP_END) begin
          frm.opcode <= sh_d[1:0];
        end
        if (cnt_d == PULSE_ADDR_END) begin
          frm.addr <= sh_d[ADDR_W-1:0];
        end
        if (cnt_d >= PULSE_WORD_END && word_pos[3:0] == 4'h0 && word_pos[6] == 1'b0) begin
          frm.words[word_pos[5:4]] <= sh_d;
        end
      end
    end
  end

endmodule // wfpc_link_capture

`default_nettype wire

// ### tb/wfpc_pulse_guard_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// frame verdict checks
module wfpc_pulse_guard_sva #(
  parameter int unsigned PROG_CNT = 50
) (
  // core clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial link
  input wire logic sel,
  input wire logic dout,
  input wire logic dout_oe_n,
  // verdicts
  input wire logic accept_pulse,
  input wire logic reject_pulse,
  input wire logic busy,
  input wire logic guard_store_pulse,
  input wire logic guard_erase_pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // counts busy cycles so the length can be judged at the falling edge
  logic [19:0] busy_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (rst || !busy) busy_cnt_q <= 20'h00000;
    else busy_cnt_q <= busy_cnt_q + 20'h00001;
  end

  verdict_excl_a: assert property (!(accept_pulse && reject_pulse))
    else $error("accept and reject in one cycle");
  busy_start_a: assert property ($rose(busy) |-> accept_pulse)
    else $error("programming started without accept");
  accept_busy_a: assert property (accept_pulse |-> busy)
    else $error("accept without programming");
  reject_idle_a: assert property (reject_pulse |=> !busy)
    else $error("programming after reject");
  busy_out_a: assert property (busy && !dout_oe_n |-> !dout)
    else $error("ready shown while programming");
  busy_len_a: assert property ($fell(busy) |-> busy_cnt_q == 20'(PROG_CNT))
    else $error("programming length wrong");
  store_accept_a: assert property (guard_store_pulse |-> accept_pulse && !guard_erase_pulse)
    else $error("guard store without accept");
  erase_accept_a: assert property (guard_erase_pulse |-> accept_pulse)
    else $error("guard erase without accept");
  release_out_a: assert property ($fell(sel) |-> ##[1:6] dout_oe_n)
    else $error("output still driven after deselect");

  cover property (accept_pulse);
  cover property (reject_pulse);
  cover property (guard_store_pulse);
  cover property (busy && !dout_oe_n);
endmodule // wfpc_pulse_guard_sva

`default_nettype wire

// ### tb/wfpc_host.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// host model: link clock only runs inside a frame
module wfpc_host (
  // serial link driven by the host
  output logic frame_clk,
  output logic sel,
  output logic din
);
  initial begin
    frame_clk = 1'b0;
    sel       = 1'b0;
    din       = 1'b0;
  end

  task automatic frame(input logic [74:0] bits, input int n);
    int i;
    #3;
    sel = 1'b1;
    for (i = n - 1; i >= 0; i--) begin
      din = bits[i];
      #16 frame_clk = 1'b1;
      #16 frame_clk = 1'b0;
    end
    #4 sel = 1'b0;
    din = ~din;
    #60;
  endtask

  // select without clocking, used to read the status output
  task automatic probe(input int ns);
    sel = 1'b1;
    din = ~din;
    #ns sel = 1'b0;
  endtask
endmodule // wfpc_host

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

// ============================================================
// bench top
module testbench;
  import wfpc_pkg::*;
  // long enough for a fill to write all 256 words while busy
  localparam int unsigned PROG_CNT = 300;

  logic              ref_clk   = 1'b0;
  logic              rst       = 1'b1;
  logic              prot_en   = 1'b0;
  logic [ADDR_W-1:0] rd_addr   = 8'h00;
  logic              frame_clk, sel, din, dout, dout_oe_n, busy;
  logic              accept_pulse, reject_pulse, guard_store_pulse, guard_erase_pulse;
  logic [WORD_W-1:0] rd_data_q;
  logic [CNT_W-1:0]  last_cnt_q;
  logic [ADDR_W-1:0] guard_addr_q;
  logic              gs, ge;
  int                err_total = 0;
  int                num_checks = 0;
  int                acc_n = 0;
  int                rej_n = 0;
  int                gs_n = 0;
  int                ge_n = 0;

  initial forever #5 ref_clk = ~ref_clk;

  // pulses last one cycle and may pass while the host still runs its frame,
  // so they are counted mid-cycle while they stand
  always @(negedge ref_clk) begin
    if (accept_pulse === 1'b1) acc_n++;
    if (reject_pulse === 1'b1) rej_n++;
    if (guard_store_pulse === 1'b1) gs_n++;
    if (guard_erase_pulse === 1'b1) ge_n++;
  end

  wfpc_host i_wfpc_host (.frame_clk(frame_clk), .sel(sel), .din(din));

  wfpc_pulse_guard #(.PROG_CNT(PROG_CNT)) i_wfpc_pulse_guard (
    .ref_clk(ref_clk), .rst(rst), .frame_clk(frame_clk), .sel(sel), .din(din),
    .prot_en(prot_en), .dout(dout), .dout_oe_n(dout_oe_n), .rd_addr(rd_addr),
    .rd_data_q(rd_data_q), .accept_pulse(accept_pulse), .reject_pulse(reject_pulse),
    .last_cnt_q(last_cnt_q), .busy(busy), .guard_store_pulse(guard_store_pulse),
    .guard_erase_pulse(guard_erase_pulse), .guard_addr_q(guard_addr_q));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    rd_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("rd_data_q", e, rd_data_q)
  endtask

  // one frame, then the verdict; optionally reads the status while busy
  task automatic send(input logic [74:0] b, input int n, input logic acc, input logic prb);
    int k;
    int a0;
    int r0;
    int s0;
    int e0;
    a0 = acc_n;
    r0 = rej_n;
    s0 = gs_n;
    e0 = ge_n;
    i_wfpc_host.frame(b, n);
    for (k = 0; k < 20 && acc_n == a0 && rej_n == r0; k++) begin
      @(posedge ref_clk);
      #1;
    end
    gs = (gs_n != s0);
    ge = (ge_n != e0);
    `CHK("accept_pulse", int'(acc), acc_n - a0)
    `CHK("reject_pulse", int'(!acc), rej_n - r0)
    `CHK("last_cnt_q", 7'(n), last_cnt_q)
    if (prb) begin
      fork i_wfpc_host.probe(150); join_none
      repeat (8) @(posedge ref_clk);
      #1;
      `CHK("dout", 1'b0, dout)
      `CHK("dout_oe_n", 1'b0, dout_oe_n)
    end
    for (k = 0; k < 600 && busy !== 1'b0; k++) @(posedge ref_clk);
    #1;
    `CHK("busy", 1'b0, busy)
    repeat (10) @(posedge ref_clk);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd(8'h00, ERASED_WORD);
    rd(8'hFF, ERASED_WORD);
    $display("test erased done");
    send({1'b1, 2'b01, 8'h12, 16'hA5C3}, 27, 1'b1, 1'b1);
    rd(8'h12, 16'hA5C3);
    $display("test word_write done");
    send({1'b1, 2'b01, 8'h20, 16'h1234, 1'b0}, 28, 1'b0, 1'b0);
    send({1'b1, 2'b01, 8'h20, 15'h091A}, 26, 1'b0, 1'b0);
    rd(8'h20, ERASED_WORD);
    send({1'b1, 2'b01, 8'h21, 16'h0F0F}, 27, 1'b1, 1'b0);
    rd(8'h21, 16'h0F0F);
    $display("test bad_count done");
    send({1'b1, 2'b11, 8'h41, 16'h1111, 16'h2222}, 43, 1'b1, 1'b0);
    rd(8'h42, 16'h2222);
    send({1'b1, 2'b11, 8'h44, 16'h3333, 16'h4444, 1'b0}, 44, 1'b0, 1'b0);
    rd(8'h44, ERASED_WORD);
    $display("test page done");
    send({1'b1, 2'b00, 8'h40, 16'h5A5A}, 27, 1'b1, 1'b0);
    rd(8'h12, 16'h5A5A);
    rd(8'hFF, 16'h5A5A);
    $display("test fill_all done");
    prot_en <= 1'b1;
    repeat (5) @(posedge ref_clk);
    send({1'b1, 2'b11, 8'h80}, 11, 1'b1, 1'b0);
    `CHK("guard_store_pulse", 1'b1, gs)
    `CHK("guard_addr_q", 8'h80, guard_addr_q)
    send({1'b1, 2'b11, 8'h90, 1'b0}, 12, 1'b0, 1'b0);
    `CHK("guard_addr_q", 8'h80, guard_addr_q)
    send({1'b1, 2'b00, 8'hC0}, 11, 1'b1, 1'b0);
    `CHK("guard_erase_pulse", 1'b1, ge)
    prot_en <= 1'b0;
    $display("test guard done");
    stop_test();
  end

  // whole run needs well under 200 us
  initial begin
    #500000;
    err_total++;
    stop_test();
  end
endmodule // testbench

bind wfpc_pulse_guard wfpc_pulse_guard_sva #(.PROG_CNT(PROG_CNT)) i_wfpc_pulse_guard_sva (
  .ref_clk(ref_clk), .rst(rst), .sel(sel), .dout(dout), .dout_oe_n(dout_oe_n),
  .accept_pulse(accept_pulse), .reject_pulse(reject_pulse), .busy(busy),
  .guard_store_pulse(guard_store_pulse), .guard_erase_pulse(guard_erase_pulse));

`default_nettype wire
